//--- design/oblc_loader.sv
// Option byte loader: fetches option bytes at reset and applies them.
//
// Chosen here: the register addresses and the APB interface to the registers.
`timescale 1ns/1ps
`default_nettype none

// ********************************************************************
// Operation
//R1: After every reset the five option bytes are read from low flash.
//R2: With boot swap active the bytes come from the mirrored range.
//R3: The programmer must fill the mirror with the same values first.
//R4: Byte 0 sets oscillator lock, watchdog interval, run and window.
//R5: With default start set, reset is held until the high level is met.
//R6: With default start clear, reset is held until the low level is met.
//R7: Slow supply ramps are advised to use the default start option.
//R8: Only the external programmer may write the default start byte.
//R9: Byte 2 picks one of two high-speed oscillator frequencies.
//R10: Byte 3 picks which pin pair carries debug clock and data.
//R11: Byte 4 picks debug off, on with erase, or on without erase.
//R12: A failed debug authentication erases flash only in erase mode.
//R13: Window codes 00 to 11 mean 25, 50, 75 and 100 percent open.
//R14: Overflow codes 000 to 111 mean 2^7,8,9,10,12,14,15,17 periods.
//R15: Bit 0 of byte 1 is the default start control, upper bits unused.
//R16: Bit 0 of byte 2 at zero means 8 MHz, upper bits unused.
//R17: Fetched values are latched and held until the next reset.
module oblc_loader (
    input wire logic REF_CLK,
    input wire logic RESET_N,
    input wire logic CLK_EN,
    input wire logic PSEL,
    input wire logic PENABLE,
    input wire logic PWRITE,
    input wire logic [7:0] PADDR,
    input wire logic [31:0] PWDATA,
    output logic [31:0] PRDATA,
    output logic PREADY,
    output logic PSLVERR,
    output logic FLASH_RD,
    output logic [15:0] FLASH_ADDR,
    input wire logic [7:0] FLASH_RDATA,
    input wire logic FLASH_RVALID,
    input wire logic BOOT_SWAP,
    input wire logic FLASH_WR_REQ,
    input wire logic [15:0] FLASH_WR_ADDR,
    input wire logic FLASH_WR_BY_PROG,
    output logic FLASH_WR_GRANT,
    input wire logic LVD_ABOVE_HI,
    input wire logic LVD_ABOVE_LO,
    input wire logic AUTH_FAIL,
    output logic FLASH_ERASE,
    output logic SYS_RESET_N,
    output logic CFG_VALID,
    output logic LS_OSC_LOCK,
    output logic LS_OSC_STOP,
    output logic WDT_COUNTER_ON,
    output logic [4:0] WDT_OVF_EXP,
    output logic [1:0] WDT_WINDOW_SEL,
    output logic [6:0] WDT_WINDOW_PCT,
    output logic LVD_DEFAULT_START,
    output logic HS_OSC_FREQ_SEL,
    output logic DEBUG_PIN_PAIR_SEL,
    output logic DEBUG_EN,
    output logic DEBUG_ERASE_ON_FAIL
);
    // ****************************************************************
    // Input synchronisers for the supply comparators
    // ****************************************************************
    // The comparators switch on a slow supply ramp and may change at any
    // time, so only the second flop of each pair feeds the logic.
    logic hi_s1_q, hi_s2_q, lo_s1_q, lo_s2_q;
    always_ff @(posedge REF_CLK) begin
        if (!RESET_N) begin
            hi_s1_q <= 1'b0;
            hi_s2_q <= 1'b0;
            lo_s1_q <= 1'b0;
            lo_s2_q <= 1'b0;
        end else if (CLK_EN) begin
            hi_s1_q <= LVD_ABOVE_HI;
            hi_s2_q <= hi_s1_q;
            lo_s1_q <= LVD_ABOVE_LO;
            lo_s2_q <= lo_s1_q;
        end
    end

    // ****************************************************************
    // Fetch sequencer
    // ****************************************************************
    oblc_pkg::oblc_state_t state_q, state_d;
    logic [2:0] idx_q;
    logic swap_q;
    logic [7:0] opt_q [oblc_pkg::OPT_COUNT];
    logic last_byte, supply_ok;
    logic [15:0] base_addr;

    assign last_byte = (idx_q == oblc_pkg::OPT_IDX_LAST);
    assign base_addr = swap_q ? oblc_pkg::OPT_BASE_SWAP
                              : oblc_pkg::OPT_BASE_MAIN; // [R2]
    // Threshold depends on the latched default start byte, byte 1. [R5] [R6]
    assign supply_ok = opt_q[oblc_pkg::OPT_IDX_LVD][oblc_pkg::POS_LVD_START]
                       ? hi_s2_q : lo_s2_q;

    always_comb begin
        state_d = state_q;
        unique case (state_q)
            oblc_pkg::OBLC_FETCH: state_d = oblc_pkg::OBLC_WAIT;
            oblc_pkg::OBLC_WAIT: begin
                if (FLASH_RVALID) begin
                    state_d = last_byte ? oblc_pkg::OBLC_HOLD
                                        : oblc_pkg::OBLC_FETCH;
                end
            end
            oblc_pkg::OBLC_HOLD: begin
                if (supply_ok) begin
                    state_d = oblc_pkg::OBLC_RUN;
                end
            end
            oblc_pkg::OBLC_RUN: state_d = oblc_pkg::OBLC_RUN;
        endcase
    end

    always_ff @(posedge REF_CLK) begin
        if (!RESET_N) begin
            state_q <= oblc_pkg::OBLC_FETCH;
            idx_q <= 3'h0;
            swap_q <= 1'b0;
            FLASH_RD <= 1'b0;
            FLASH_ADDR <= oblc_pkg::OPT_BASE_MAIN;
        end else if (CLK_EN) begin
            state_q <= state_d;
            FLASH_RD <= (state_q == oblc_pkg::OBLC_FETCH); // [R1]
            if (state_q == oblc_pkg::OBLC_FETCH) begin
                if (idx_q == 3'h0) begin
                    swap_q <= BOOT_SWAP; // [R2]
                end
                FLASH_ADDR <= (idx_q == 3'h0)
                    ? (BOOT_SWAP ? oblc_pkg::OPT_BASE_SWAP
                                 : oblc_pkg::OPT_BASE_MAIN)
                    : base_addr + {13'h0000, idx_q}; // [R1] [R2]
            end
            if (state_q == oblc_pkg::OBLC_WAIT && FLASH_RVALID) begin
                idx_q <= idx_q + 3'h1;
            end
        end
    end

    // Option bytes are written only while fetching, so they stay put
    // through any later flash programming until the next reset.
    always_ff @(posedge REF_CLK) begin
        if (!RESET_N) begin
            for (int i = 0; i < oblc_pkg::OPT_COUNT; i++) begin
                opt_q[i] <= oblc_pkg::OPT_RESET;
            end
        end else if (CLK_EN && state_q == oblc_pkg::OBLC_WAIT
                     && FLASH_RVALID) begin
            opt_q[idx_q] <= FLASH_RDATA; // [R17]
        end
    end

    // ****************************************************************
    // Decoded settings
    // ****************************************************************
    oblc_pkg::oblc_cfg_t cfg;
    assign cfg.ls_osc_lock = opt_q[0][oblc_pkg::POS_LS_LOCK]; // [R4]
    assign cfg.wdt_ovf_sel =
        opt_q[0][oblc_pkg::POS_OVF_LO +: 3]; // [R4]
    assign cfg.wdt_on = opt_q[0][oblc_pkg::POS_WDT_ON]; // [R4]
    assign cfg.wdt_win_sel = opt_q[0][oblc_pkg::POS_WIN_LO +: 2]; // [R4]
    // Only bit 0 is honoured; stray upper bits are ignored. [R15] [R16]
    assign cfg.lvd_start = opt_q[1][oblc_pkg::POS_LVD_START];
    assign cfg.hs_sel = opt_q[2][oblc_pkg::POS_HS_SEL]; // [R9]
    assign cfg.pin_sel = opt_q[3][oblc_pkg::POS_PIN_SEL]; // [R10]
    assign cfg.dbg_en = opt_q[4][oblc_pkg::POS_DBG_LO +: 2]; // [R11]

    logic running, dbg_on, dbg_erase, lvd_byte_wr, ctrl_stop_q;
    assign running = (state_q == oblc_pkg::OBLC_RUN);
    // The prohibited code 01 is treated as debug off.
    assign dbg_on = cfg.dbg_en[1]; // [R11]
    assign dbg_erase = cfg.dbg_en[1] & cfg.dbg_en[0]; // [R11]
    // Both copies of the default start byte are guarded, so a boot swap
    // cannot be used to sneak a self-programmed value in.
    assign lvd_byte_wr =
        FLASH_WR_ADDR == oblc_pkg::OPT_BASE_MAIN
            + {13'h0000, oblc_pkg::OPT_IDX_LVD}
        || FLASH_WR_ADDR == oblc_pkg::OPT_BASE_SWAP
            + {13'h0000, oblc_pkg::OPT_IDX_LVD}; // [R8]

    always_ff @(posedge REF_CLK) begin
        if (!RESET_N) begin
            SYS_RESET_N <= 1'b0;
            CFG_VALID <= 1'b0;
            LS_OSC_LOCK <= 1'b0;
            LS_OSC_STOP <= 1'b0;
            WDT_COUNTER_ON <= 1'b0;
            WDT_OVF_EXP <= 5'h00;
            WDT_WINDOW_SEL <= 2'h0;
            WDT_WINDOW_PCT <= 7'h00;
            LVD_DEFAULT_START <= 1'b0;
            HS_OSC_FREQ_SEL <= 1'b0;
            DEBUG_PIN_PAIR_SEL <= 1'b0;
            DEBUG_EN <= 1'b0;
            DEBUG_ERASE_ON_FAIL <= 1'b0;
            FLASH_WR_GRANT <= 1'b0;
            FLASH_ERASE <= 1'b0;
        end else if (CLK_EN) begin
            SYS_RESET_N <= running; // [R5] [R6]
            CFG_VALID <= running;
            LS_OSC_LOCK <= cfg.ls_osc_lock;
            // A locked low-speed oscillator ignores the software stop.
            LS_OSC_STOP <= ctrl_stop_q & ~cfg.ls_osc_lock; // [R4]
            WDT_COUNTER_ON <= cfg.wdt_on & running;
            WDT_OVF_EXP <= oblc_pkg::ovf_exp(cfg.wdt_ovf_sel); // [R14]
            WDT_WINDOW_SEL <= cfg.wdt_win_sel;
            WDT_WINDOW_PCT <= oblc_pkg::win_pct(cfg.wdt_win_sel); // [R13]
            LVD_DEFAULT_START <= cfg.lvd_start; // [R15]
            HS_OSC_FREQ_SEL <= cfg.hs_sel; // [R16]
            DEBUG_PIN_PAIR_SEL <= cfg.pin_sel; // [R10]
            DEBUG_EN <= dbg_on & running;
            DEBUG_ERASE_ON_FAIL <= dbg_erase;
            FLASH_WR_GRANT <= FLASH_WR_REQ
                & (FLASH_WR_BY_PROG | ~lvd_byte_wr); // [R8]
            FLASH_ERASE <= AUTH_FAIL & dbg_erase & running; // [R12]
        end
    end

    // ****************************************************************
    // APB slave, one wait state
    // ****************************************************************
    logic acc, wr_fire, hit;
    logic [31:0] rd_mux;
    assign acc = PSEL & PENABLE & ~PREADY;
    assign wr_fire = PSEL & PENABLE & PREADY & PWRITE & ~PSLVERR;
    assign hit = PADDR <= oblc_pkg::REG_CTRL && PADDR[1:0] == 2'h0;

    always_comb begin
        rd_mux = 32'h0000_0000;
        unique case (PADDR)
            oblc_pkg::REG_OPT_WDT: rd_mux[7:0] = opt_q[0];
            oblc_pkg::REG_OPT_LVD: rd_mux[7:0] = opt_q[1];
            oblc_pkg::REG_OPT_HSO: rd_mux[7:0] = opt_q[2];
            oblc_pkg::REG_OPT_PIN: rd_mux[7:0] = opt_q[3];
            oblc_pkg::REG_OPT_DBG: rd_mux[7:0] = opt_q[4];
            oblc_pkg::REG_STATUS: rd_mux[3:0] = {swap_q, running, state_q};
            oblc_pkg::REG_CTRL: rd_mux[0] = ctrl_stop_q;
            default: rd_mux = 32'h0000_0000;
        endcase
    end

    always_ff @(posedge REF_CLK) begin
        if (!RESET_N) begin
            PREADY <= 1'b0;
            PSLVERR <= 1'b0;
            PRDATA <= 32'h0000_0000;
            ctrl_stop_q <= oblc_pkg::CTRL_RESET;
        end else if (CLK_EN) begin
            PREADY <= acc;
            PSLVERR <= acc & ~hit;
            if (acc && !PWRITE) begin
                PRDATA <= hit ? rd_mux : 32'h0000_0000;
            end
            if (wr_fire && PADDR == oblc_pkg::REG_CTRL) begin
                ctrl_stop_q <= PWDATA[0];
            end
        end
    end

    // ****************************************************************
    // Checks
    // ****************************************************************
    default clocking cb @(posedge REF_CLK); endclocking
    default disable iff (!RESET_N || !CLK_EN);

    chk_fetch_main: assert property (FLASH_RD && !swap_q |-> // [R1]
        FLASH_ADDR[15:3] == oblc_pkg::OPT_BASE_MAIN[15:3])
        else $error("fetch outside main option range");
    chk_fetch_swap: assert property (FLASH_RD && swap_q |-> // [R2]
        FLASH_ADDR[15:3] == oblc_pkg::OPT_BASE_SWAP[15:3])
        else $error("swap fetch outside mirror range");
    chk_release_hi: assert property ($rose(SYS_RESET_N) // [R5]
        && LVD_DEFAULT_START |-> $past(hi_s2_q, 2))
        else $error("release before high threshold");
    chk_release_lo: assert property ($rose(SYS_RESET_N) // [R6]
        && !LVD_DEFAULT_START |-> $past(lo_s2_q, 2))
        else $error("release before low threshold");
    chk_lvd_write: assert property (FLASH_WR_REQ && lvd_byte_wr // [R8]
        && !FLASH_WR_BY_PROG |=> !FLASH_WR_GRANT)
        else $error("self write to default start byte granted");
    chk_erase_mode: assert property (FLASH_ERASE |-> // [R12]
        $past(AUTH_FAIL) && DEBUG_ERASE_ON_FAIL)
        else $error("erase without erase mode and failure");
    chk_window_pct: assert property (WDT_WINDOW_SEL == 2'h1 // [R13]
        |-> WDT_WINDOW_PCT == oblc_pkg::WIN_PCT_1)
        else $error("window percent mismatch");
    chk_ovf_exp: assert property (running && cfg.wdt_ovf_sel == 3'h4 // [R14]
        |=> WDT_OVF_EXP == 5'h0C)
        else $error("overflow exponent mismatch");
    chk_cfg_hold: assert property (running |=> $stable(cfg)) // [R17]
        else $error("settings changed after load");
    chk_hs_sel: assert property (running |=> // [R9]
        HS_OSC_FREQ_SEL == $past(opt_q[2][0]))
        else $error("frequency select not applied");
    chk_keep_flash: assert property (AUTH_FAIL && !dbg_erase // [R12]
        |=> !FLASH_ERASE)
        else $error("erase while erase mode is off");

    cov_swap_boot: cover property ($rose(SYS_RESET_N) && swap_q);
    cov_hold_wait: cover property (state_q == oblc_pkg::OBLC_HOLD [*3]);
    cov_erase: cover property (FLASH_ERASE);
    cov_self_lvd_write: cover property (FLASH_WR_REQ && lvd_byte_wr
        && !FLASH_WR_BY_PROG);
endmodule : oblc_loader

`default_nettype wire

//--- design/oblc_pkg.sv
// Package of constants, types and helpers for the option byte loader.
package oblc_pkg;
    // ****************************************************************
    // Flash option area
    // ****************************************************************
    localparam logic [15:0] OPT_BASE_MAIN = 16'h0080;
    localparam logic [15:0] OPT_BASE_SWAP = 16'h1080;
    localparam int OPT_COUNT = 5;
    localparam logic [2:0] OPT_IDX_WDT = 3'h0;
    localparam logic [2:0] OPT_IDX_LVD = 3'h1;
    localparam logic [2:0] OPT_IDX_HSO = 3'h2;
    localparam logic [2:0] OPT_IDX_PIN = 3'h3;
    localparam logic [2:0] OPT_IDX_DBG = 3'h4;
    localparam logic [2:0] OPT_IDX_LAST = 3'h4;
    // Field positions inside the option bytes.
    localparam int POS_LS_LOCK = 0;
    localparam int POS_OVF_LO = 1;
    localparam int POS_WDT_ON = 4;
    localparam int POS_WIN_LO = 5;
    localparam int POS_LVD_START = 0;
    localparam int POS_HS_SEL = 0;
    localparam int POS_PIN_SEL = 1;
    localparam int POS_DBG_LO = 0;
    // ****************************************************************
    // APB register map
    // ****************************************************************
    localparam logic [7:0] REG_OPT_WDT = 8'h00;
    localparam logic [7:0] REG_OPT_LVD = 8'h04;
    localparam logic [7:0] REG_OPT_HSO = 8'h08;
    localparam logic [7:0] REG_OPT_PIN = 8'h0C;
    localparam logic [7:0] REG_OPT_DBG = 8'h10;
    localparam logic [7:0] REG_STATUS = 8'h14;
    localparam logic [7:0] REG_CTRL = 8'h18;
    localparam logic [7:0] OPT_RESET = 8'h00;
    localparam logic CTRL_RESET = 1'b0;
    // Window open period in percent per two-bit code.
    localparam logic [6:0] WIN_PCT_0 = 7'h19;
    localparam logic [6:0] WIN_PCT_1 = 7'h32;
    localparam logic [6:0] WIN_PCT_2 = 7'h4B;
    localparam logic [6:0] WIN_PCT_3 = 7'h64;
    // ****************************************************************
    // Types
    // ****************************************************************
    typedef enum logic [1:0] {
        OBLC_FETCH = 2'b00,
        OBLC_WAIT = 2'b01,
        OBLC_HOLD = 2'b11,
        OBLC_RUN = 2'b10
    } oblc_state_t;
    typedef struct packed {
        logic ls_osc_lock;
        logic [2:0] wdt_ovf_sel;
        logic wdt_on;
        logic [1:0] wdt_win_sel;
        logic lvd_start;
        logic hs_sel;
        logic pin_sel;
        logic [1:0] dbg_en;
    } oblc_cfg_t;

    function automatic logic [4:0] ovf_exp(input logic [2:0] code);
        logic [4:0] e;
        e = 5'h07;
        case (code)
            3'h0: e = 5'h07;
            3'h1: e = 5'h08;
            3'h2: e = 5'h09;
            3'h3: e = 5'h0A;
            3'h4: e = 5'h0C;
            3'h5: e = 5'h0E;
            3'h6: e = 5'h0F;
            default: e = 5'h11;
        endcase
        return e;
    endfunction : ovf_exp

    function automatic logic [6:0] win_pct(input logic [1:0] code);
        logic [6:0] p;
        p = WIN_PCT_0;
        case (code)
            2'h0: p = WIN_PCT_0;
            2'h1: p = WIN_PCT_1;
            2'h2: p = WIN_PCT_2;
            default: p = WIN_PCT_3;
        endcase
        return p;
    endfunction : win_pct
endpackage : oblc_pkg

//--- tb/oblc_flash_model.sv
// Flash array model that answers option byte reads.
`timescale 1ns/1ps
`default_nettype none
module oblc_flash_model (
    input wire logic clk,
    input wire logic rd,
    input wire logic [15:0] addr,
    input wire logic slow,
    output logic [7:0] rdata,
    output logic rvalid
);
    // ****************************************************************
    // Read port
    // ****************************************************************
    // Mirror range returns the same bytes as the main range.
    logic [7:0] mem [5];
    int cnt = -1;
    initial begin
        rvalid = 1'b0;
        rdata = 8'h00;
    end
    // A released data bus flips every cycle, so stale bytes never pass.
    always @(posedge clk) begin
        rvalid <= 1'b0;
        rdata <= ~rdata;
        if (rd) begin
            cnt <= slow ? 3 : 0;
        end else if (cnt == 0) begin
            rvalid <= 1'b1;
            rdata <= mem[addr[2:0]];
            cnt <= -1;
        end else if (cnt > 0) begin
            cnt <= cnt - 1;
        end
    end
endmodule : oblc_flash_model
`default_nettype wire

//--- tb/oblc_loader_tb.sv
// Self-checking testbench for the option byte loader.
`timescale 1ns/1ps
`default_nettype none
module oblc_loader_tb;
    logic clk = 1'b0, rst_n = 1'b0, swap = 1'b0, slow = 1'b0;
    logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0, prdata;
    logic pready, pslverr, frd, fvalid, grant, erase, sys_n, cfg_v;
    logic [15:0] faddr, wr_addr = 16'h0;
    logic [7:0] frdata;
    logic wr_req = 1'b0, wr_prog = 1'b0, hi = 1'b0, lo = 1'b0;
    logic auth = 1'b0, lock, stop, wdt_on, lvd, hs, pin, dbg_en, dbg_er;
    logic [4:0] ovf;
    logic [1:0] win;
    logic [6:0] pct;
    logic [7:0] b [5];
    logic [15:0] exp_fa [$];
    logic [32:0] exp_rd [$];
    logic [4:0] ovf_tab [8] = '{5'h07, 5'h08, 5'h09, 5'h0A, 5'h0C, 5'h0E,
                                5'h0F, 5'h11};
    logic [6:0] pct_tab [4] = '{7'h19, 7'h32, 7'h4B, 7'h64};
    int miscompares = 0;
    int n_checks = 0;

    always #50 clk = ~clk;

    oblc_loader dut (
        .REF_CLK(clk), .RESET_N(rst_n), .CLK_EN(1'b1),
        .PSEL(psel), .PENABLE(penable), .PWRITE(pwrite), .PADDR(paddr),
        .PWDATA(pwdata), .PRDATA(prdata), .PREADY(pready),
        .PSLVERR(pslverr), .FLASH_RD(frd), .FLASH_ADDR(faddr),
        .FLASH_RDATA(frdata), .FLASH_RVALID(fvalid), .BOOT_SWAP(swap),
        .FLASH_WR_REQ(wr_req), .FLASH_WR_ADDR(wr_addr),
        .FLASH_WR_BY_PROG(wr_prog), .FLASH_WR_GRANT(grant),
        .LVD_ABOVE_HI(hi), .LVD_ABOVE_LO(lo), .AUTH_FAIL(auth),
        .FLASH_ERASE(erase), .SYS_RESET_N(sys_n), .CFG_VALID(cfg_v),
        .LS_OSC_LOCK(lock), .LS_OSC_STOP(stop), .WDT_COUNTER_ON(wdt_on),
        .WDT_OVF_EXP(ovf), .WDT_WINDOW_SEL(win), .WDT_WINDOW_PCT(pct),
        .LVD_DEFAULT_START(lvd), .HS_OSC_FREQ_SEL(hs),
        .DEBUG_PIN_PAIR_SEL(pin), .DEBUG_EN(dbg_en),
        .DEBUG_ERASE_ON_FAIL(dbg_er)
    );

    oblc_flash_model model (
        .clk(clk), .rd(frd), .addr(faddr), .slow(slow),
        .rdata(frdata), .rvalid(fvalid)
    );

    // ****************************************************************
    // Checking and bus tasks
    // ****************************************************************
    task automatic check(string what, logic [32:0] e, logic [32:0] s);
        n_checks++;
        if (s !== e) begin
            miscompares++;
            $display("MISMATCH %s expected %h seen %h", what, e, s);
        end
    endtask : check

    task automatic final_report();
        $display("checks %0d mismatches %0d", n_checks, miscompares);
        if (miscompares == 0 && n_checks > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask : final_report

    // The master holds the request until it samples the ready pulse;
    // only the watchdog ends a wait that never gets an answer.
    task automatic apb(logic wr, logic [7:0] a, logic [31:0] d,
                       logic [32:0] e);
        exp_rd.push_back(e);
        @(posedge clk);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        do @(posedge clk); while (pready !== 1'b1);
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb

    task automatic check_cfg();
        check("ls_lock", b[0][0], lock);
        check("wdt_ovf", ovf_tab[b[0][3:1]], ovf);
        check("wdt_on", b[0][4], wdt_on);
        check("wdt_win", b[0][6:5], win);
        check("wdt_pct", pct_tab[b[0][6:5]], pct);
        check("lvd_start", b[1][0], lvd);
        check("hs_sel", b[2][0], hs);
        check("pin_sel", b[3][1], pin);
        check("dbg_en", b[4][1], dbg_en);
        check("dbg_erase", &b[4][1:0], dbg_er);
    endtask : check_cfg

    always @(posedge clk) begin
        logic [32:0] e;
        if (frd === 1'b1) begin
            check("flash_addr", exp_fa.pop_front(), faddr);
        end
        if (psel && penable && pready === 1'b1) begin
            e = exp_rd.pop_front();
            if (pwrite) begin
                check("apb_err", e[32], pslverr);
            end else begin
                check("apb_rd", e, {pslverr, prdata});
            end
        end
    end

    initial begin
        #(100 * 30000);
        miscompares++;
        final_report();
    end

    initial begin
        logic [7:0] r;
        void'($urandom(32'h5301));
        for (int i = 0; i < 8; i++) begin
            r = 8'($urandom);
            b[0] = {1'b0, 2'(i + 1), r[4], 3'(i), r[0]};
            // Default start is set exactly when the high comparator comes
            // late, as a user would do for a slow supply ramp.
            b[1] = {7'h00, i[0]};
            b[2] = {7'h00, r[1]};
            b[3] = {3'h0, 3'h7, r[2], 1'b0};
            b[4] = {6'h00, 2'(i)};
            for (int k = 0; k < 5; k++) model.mem[k] = b[k];
            for (int k = 0; k < 5; k++) begin
                exp_fa.push_back((i[1] ? 16'h1080 : 16'h0080) + 16'(k));
            end
            @(posedge clk);
            swap <= i[1];
            slow <= i[2];
            hi <= 1'b0;
            lo <= i[0];
            rst_n <= 1'b0;
            repeat (10) @(posedge clk);
            rst_n <= 1'b1;
            repeat (60) @(posedge clk);
            #1;
            check("fetches", 33'h0, exp_fa.size());
            check("sys_rst_n", 1'b0, sys_n);
            check("cfg_valid", 1'b0, cfg_v);
            @(posedge clk);
            hi <= i[0];
            lo <= 1'b1;
            for (int k = 0; k < 20 && sys_n !== 1'b1; k++) @(posedge clk);
            #1;
            check("sys_rst_n", 1'b1, sys_n);
            check("cfg_valid", 1'b1, cfg_v);
            check_cfg();
            for (int k = 0; k < 5; k++) begin
                apb(1'b0, 8'(4 * k), 32'h0, b[k]);
            end
            apb(1'b0, 8'h14, 32'h0, {29'h0, i[1], 3'h6});
            apb(1'b1, 8'h00, 32'hFF, 33'h0);
            apb(1'b0, 8'h00, 32'h0, b[0]);
            apb(1'b0, 8'h1C, 32'h0, 33'h100000000);
            apb(1'b1, 8'h1C, 32'h0, 33'h100000000);
            apb(1'b1, 8'h18, {31'h0, r[3]}, 33'h0);
            apb(1'b0, 8'h18, 32'h0, r[3]);
            @(posedge clk);
            #1;
            check("ls_stop", r[3] & ~b[0][0], stop);
            for (int k = 0; k < 6; k++) begin
                @(posedge clk);
                wr_req <= 1'b1;
                wr_prog <= k[0];
                wr_addr <= k < 2 ? 16'h0081 : k < 4 ? 16'h1081 : 16'h0082;
                @(posedge clk);
                #1;
                check("wr_grant", k[0] | (k > 3), grant);
            end
            @(posedge clk);
            wr_req <= 1'b0;
            auth <= 1'b1;
            @(posedge clk);
            auth <= 1'b0;
            #1;
            check("erase", &b[4][1:0], erase);
            for (int k = 0; k < 5; k++) model.mem[k] = ~b[k];
            repeat (3) @(posedge clk);
            #1;
            check("erase_end", 1'b0, erase);
            check_cfg();
        end
        final_report();
    end
endmodule : oblc_loader_tb
`default_nettype wire
